// ===== hdl/clock_select_cfg.svh
// offsets, field positions, reset values and timing counts of the clock select block
`ifndef CLOCK_SELECT_CFG_SVH
`define CLOCK_SELECT_CFG_SVH

// register indices on the plain register port
`define DIVISOR_IDX 4'h0
`define FEEDBACK_IDX 4'h1
`define STATUS_IDX 4'h2

// clock_divisor_reg fields
`define RC_POST_HI 10
`define RC_POST_LO 8
`define PLL_POST_HI 7
`define PLL_POST_LO 6
`define PLL_PRE_HI 4
`define PLL_PRE_LO 0

// pll_feedback_reg field
`define FBD_HI 8
`define FBD_LO 0

// status fields
`define ST_SRC_HI 2
`define ST_SRC_LO 0
`define ST_SUB_HI 4
`define ST_SUB_LO 3
`define ST_PLL_BIT 5
`define ST_REL_BIT 6
`define ST_IO_BIT 7

// reset values
`define RC_POST_RST 3'h0
`define PLL_POST_RST 2'h1
`define PLL_PRE_RST 5'h00
`define FBD_RST 9'h030

// source select codes
`define SRC_FRC 3'h0
`define SRC_FRC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define SRC_SECONDARY_OSCILLATOR 3'h4
`define SRC_LOW_POWER_INTERNAL_RC 3'h5
`define SRC_DIV16 3'h6
`define SRC_DIVN 3'h7

// primary submode codes
`define SUB_EXT 2'h0
`define SUB_XT 2'h1
`define SUB_HS 2'h2

// fixed factors
`define FCY_DIV 2
`define DIV16_DEN 16
`define PLL_OFFSET 2

// settle time before execution is released, and clock rate
`define STARTUP_NS 64
`define CLK_MHZ 250

`endif

// ===== hdl/clock_select_pkg.sv
// types and shared decoders of the clock select block
package clock_select_pkg;
`include "clock_select_cfg.svh"

	typedef enum logic [1:0] {ST_CAPTURE, ST_SETTLE, ST_RUN} boot_e;
	typedef logic [2:0] source_t;
	typedef logic [9:0] factor_t;

	// rc postscale factor; 111 jumps to 256 rather than 128
	function automatic factor_t rc_post_den(input logic [2:0] code);
		factor_t f;
		f = 10'h001;
		if (code == 3'h7) begin
			f = 10'h100;
		end else begin
			f = factor_t'(10'h001 << code);
		end
		return f;
	endfunction

	// pll postscale factor; the reserved code is served as divide by 4
	function automatic factor_t n2_den(input logic [1:0] code);
		factor_t f;
		case (code)
			2'h0: f = 10'h002;
			2'h3: f = 10'h008;
			default: f = 10'h004;
		endcase
		return f;
	endfunction
endpackage

// ===== hdl/tick_if.sv
// carrier for synchronised oscillator levels and rising-edge ticks
`timescale 1ns/1ps
interface tick_if #(parameter int N = 4);
	logic [N-1:0] level;
	logic [N-1:0] edge_tick;
	modport source(output level, output edge_tick);
	modport sink(input level, input edge_tick);
endinterface

// ===== hdl/pin_sync.sv
// three-stage pin synchroniser with agreement filter and rising-edge tick
`timescale 1ns/1ps
module pin_sync #(
	parameter int N = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// raw pins and synchronised result
	input wire logic [N-1:0] pins,
	tick_if.source out
);
	generate
		if (N < 1) begin : g_chk
			$error("pin_sync needs at least one pin");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			logic s1;
			logic s2;
			logic s3;
			logic stable;
			logic next_stable;
			logic next_tick;
			logic tick;
			// a change is accepted only when stages two and three agree
			always_comb begin
				next_stable = (s2 == s3) ? s3 : stable;
				next_tick = next_stable & ~stable;
			end
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					stable <= 1'b0;
					tick <= 1'b0;
				end else begin
					s1 <= pins[i];
					s2 <= s1;
					s3 <= s2;
					stable <= next_stable;
					tick <= next_tick;
				end
			end
			assign out.level[i] = stable;
			assign out.edge_tick[i] = tick;
		end
	endgenerate
endmodule

// ===== hdl/rate_scaler.sv
// fractional rate scaler: out rate = in rate * mul / den, by credit accumulation
`timescale 1ns/1ps
module rate_scaler #(
	parameter int ACC_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ratio and input tick
	input wire logic [9:0] mul,
	input wire logic [9:0] den,
	input wire logic in_tick,
	// scaled tick
	output logic out_tick
);
	generate
		if (ACC_W < 12) begin : g_chk
			$error("rate_scaler accumulator too narrow for the ratio range");
		end
	endgenerate

	logic [ACC_W-1:0] credit;
	logic [ACC_W-1:0] next_credit;
	logic next_out;

	// at most one tick per cycle; an input tick that would overflow the credit adds nothing to it
	always_comb begin
		next_credit = credit;
		next_out = 1'b0;
		if (credit >= ACC_W'(den)) begin
			next_credit = credit - ACC_W'(den);
			next_out = 1'b1;
		end
		if (in_tick && (next_credit <= {ACC_W{1'b1}} - ACC_W'(mul))) begin
			next_credit = next_credit + ACC_W'(mul);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			credit <= '0;
			out_tick <= 1'b0;
		end else begin
			credit <= next_credit;
			out_tick <= next_out;
		end
	end
endmodule

// ===== hdl/clock_select.sv
// system clock source selection, rc postscaler, pll ratio and instruction clock
`timescale 1ns/1ps
`include "clock_select_cfg.svh"
module clock_select
	import clock_select_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int ACC_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// nonvolatile configuration, read once after reset release
	input wire logic [2:0] initial_source_select,
	input wire logic [1:0] primary_submode_select,
	input wire logic osc_pin_function_bit,
	input wire logic config_erased,
	// oscillator pins
	input wire logic fast_rc_pin,
	input wire logic primary_osc_pin,
	input wire logic secondary_osc_pin,
	input wire logic low_power_rc_pin,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// clock results
	output logic osc_tick,
	output logic instr_tick,
	output logic low_power_internal_rc_ref_tick,
	output logic osc2_pin_is_io,
	output logic exec_release
);
	localparam int STARTUP_CNT = (`STARTUP_NS * `CLK_MHZ + 999) / 1000;
	localparam int PIN_FRC = 0;
	localparam int PIN_PRI = 1;
	localparam int PIN_SECONDARY_OSCILLATOR = 2;
	localparam int PIN_LOW_POWER_INTERNAL_RC = 3;

	generate
		if (DATA_W < 16) begin : g_chk
			$error("clock_select needs a data width of at least 16");
		end
	endgenerate

	// synchronised oscillator pins
	tick_if #(.N(4)) osc_pins ();
	pin_sync #(.N(4)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.pins({low_power_rc_pin, secondary_osc_pin, primary_osc_pin, fast_rc_pin}),
		.out(osc_pins.source)
	);

	// boot sequence state
	boot_e state;
	boot_e next_state;
	source_t src;
	source_t next_src;
	logic [1:0] submode;
	logic [1:0] next_submode;
	logic pin_func;
	logic next_pin_func;
	logic [7:0] settle;
	logic [7:0] next_settle;

	// capture the configuration one clock after reset release, then settle
	always_comb begin
		next_state = state;
		next_src = src;
		next_submode = submode;
		next_pin_func = pin_func;
		next_settle = settle;
		case (state)
			ST_CAPTURE: begin
				// the table names divide-by-N as the erased default
				next_src = config_erased ? `SRC_DIVN : initial_source_select;
				next_submode = primary_submode_select;
				next_pin_func = osc_pin_function_bit;
				next_settle = 8'h00;
				next_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				next_settle = settle + 8'h01;
				if (settle == 8'(STARTUP_CNT - 1)) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_CAPTURE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_CAPTURE;
			src <= `SRC_DIVN;
			submode <= `SUB_EXT;
			pin_func <= 1'b0;
			settle <= 8'h00;
		end else begin
			state <= next_state;
			src <= next_src;
			submode <= next_submode;
			pin_func <= next_pin_func;
			settle <= next_settle;
		end
	end

	// divider fields written by software
	logic [2:0] rc_post;
	logic [2:0] next_rc_post;
	logic [1:0] pll_post;
	logic [1:0] next_pll_post;
	logic [4:0] pll_pre;
	logic [4:0] next_pll_pre;
	logic [8:0] fbd;
	logic [8:0] next_fbd;
	logic [DATA_W-1:0] next_rdata;
	logic is_primary;
	logic pll_path;
	logic [DATA_W-1:0] status_word;

	// submode only means something for primary codes
	assign is_primary = (src == `SRC_PRI) || (src == `SRC_PRI_PLL);
	assign pll_path = (src == `SRC_PRI_PLL) || (src == `SRC_FRC_PLL);

	always_comb begin
		status_word = '0;
		status_word[`ST_SRC_HI:`ST_SRC_LO] = src;
		status_word[`ST_SUB_HI:`ST_SUB_LO] = is_primary ? submode : `SUB_EXT;
		status_word[`ST_PLL_BIT] = pll_path;
		status_word[`ST_REL_BIT] = exec_release;
		status_word[`ST_IO_BIT] = osc2_pin_is_io;
	end

	// register writes and one-cycle-late read data
	always_comb begin
		next_rc_post = rc_post;
		next_pll_post = pll_post;
		next_pll_pre = pll_pre;
		next_fbd = fbd;
		next_rdata = '0;
		if (reg_wr && reg_addr == `DIVISOR_IDX) begin
			next_rc_post = reg_wdata[`RC_POST_HI:`RC_POST_LO];
			next_pll_post = reg_wdata[`PLL_POST_HI:`PLL_POST_LO];
			next_pll_pre = reg_wdata[`PLL_PRE_HI:`PLL_PRE_LO];
		end
		if (reg_wr && reg_addr == `FEEDBACK_IDX) begin
			next_fbd = reg_wdata[`FBD_HI:`FBD_LO];
		end
		if (reg_rd) begin
			case (reg_addr)
				`DIVISOR_IDX: begin
					next_rdata[`RC_POST_HI:`RC_POST_LO] = rc_post;
					next_rdata[`PLL_POST_HI:`PLL_POST_LO] = pll_post;
					next_rdata[`PLL_PRE_HI:`PLL_PRE_LO] = pll_pre;
				end
				`FEEDBACK_IDX: begin
					next_rdata[`FBD_HI:`FBD_LO] = fbd;
				end
				`STATUS_IDX: begin
					next_rdata = status_word;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rc_post <= `RC_POST_RST;
			pll_post <= `PLL_POST_RST;
			pll_pre <= `PLL_PRE_RST;
			fbd <= `FBD_RST;
			reg_rdata <= '0;
		end else begin
			rc_post <= next_rc_post;
			pll_post <= next_pll_post;
			pll_pre <= next_pll_pre;
			fbd <= next_fbd;
			reg_rdata <= next_rdata;
		end
	end

	// ratio and source tick for the active mode; nothing runs before capture
	factor_t mul_sel;
	factor_t den_sel;
	factor_t m_fac;
	factor_t n1_fac;
	logic src_tick;

	assign m_fac = factor_t'(fbd) + factor_t'(`PLL_OFFSET);
	assign n1_fac = factor_t'(pll_pre) + factor_t'(`PLL_OFFSET);

	always_comb begin
		mul_sel = 10'h001;
		den_sel = 10'h001;
		src_tick = 1'b0;
		case (src)
			`SRC_FRC: src_tick = osc_pins.edge_tick[PIN_FRC];
			`SRC_FRC_PLL, `SRC_PRI_PLL: begin
				src_tick = (src == `SRC_FRC_PLL) ? osc_pins.edge_tick[PIN_FRC] : osc_pins.edge_tick[PIN_PRI];
				mul_sel = m_fac;
				den_sel = factor_t'(n1_fac * n2_den(pll_post));
			end
			`SRC_PRI: src_tick = osc_pins.edge_tick[PIN_PRI];
			`SRC_SECONDARY_OSCILLATOR: src_tick = osc_pins.edge_tick[PIN_SECONDARY_OSCILLATOR];
			`SRC_LOW_POWER_INTERNAL_RC: src_tick = osc_pins.edge_tick[PIN_LOW_POWER_INTERNAL_RC];
			`SRC_DIV16: begin
				src_tick = osc_pins.edge_tick[PIN_FRC];
				den_sel = factor_t'(`DIV16_DEN);
			end
			`SRC_DIVN: begin
				src_tick = osc_pins.edge_tick[PIN_FRC];
				den_sel = rc_post_den(rc_post);
			end
			default: src_tick = 1'b0;
		endcase
		if (state == ST_CAPTURE) begin
			src_tick = 1'b0;
		end
	end

	logic scaled_tick;
	rate_scaler #(.ACC_W(ACC_W)) u_scale (
		.clk(clk),
		.nrst(nrst),
		.mul(mul_sel),
		.den(den_sel),
		.in_tick(src_tick),
		.out_tick(scaled_tick)
	);

	// output clocks: every second oscillator tick is an instruction tick
	logic half;
	logic next_half;
	logic next_io;

	always_comb begin
		next_half = scaled_tick ? ~half : half;
		// crystal submodes own the second pin; other modes follow the config bit
		next_io = (is_primary && submode != `SUB_EXT) ? 1'b0 : pin_func;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			half <= 1'b0;
			osc_tick <= 1'b0;
			instr_tick <= 1'b0;
			low_power_internal_rc_ref_tick <= 1'b0;
			osc2_pin_is_io <= 1'b0;
			exec_release <= 1'b0;
		end else begin
			half <= next_half;
			osc_tick <= scaled_tick;
			instr_tick <= scaled_tick & half;
			low_power_internal_rc_ref_tick <= osc_pins.edge_tick[PIN_LOW_POWER_INTERNAL_RC];
			osc2_pin_is_io <= next_io;
			exec_release <= (state == ST_RUN);
		end
	end

	// checks on the selection, scaling, release, reset default and pin paths
	erased_default_a: assert property (@(posedge clk) disable iff (!nrst)
		(state == ST_CAPTURE && config_erased) |=> (src == `SRC_DIVN))
		else $error("erased config did not select rc divide-by-N");

	config_capture_a: assert property (@(posedge clk) disable iff (!nrst)
		(nrst && state == ST_CAPTURE && !config_erased) |=> (src == $past(initial_source_select)))
		else $error("source code not taken from config");

	instr_half_a: assert property (@(posedge clk) disable iff (!nrst)
		(osc_tick || instr_tick) |-> (osc_tick && (instr_tick != half)))
		else $error("instruction tick not on every second oscillator tick");

	bypass_pll_a: assert property (@(posedge clk) disable iff (!nrst)
		(src == `SRC_SECONDARY_OSCILLATOR || src == `SRC_LOW_POWER_INTERNAL_RC || src == `SRC_FRC || src == `SRC_PRI)
		|-> (mul_sel == 10'h001 && den_sel == 10'h001))
		else $error("pll ratio on a bypass source");

	div16_ratio_a: assert property (@(posedge clk) disable iff (!nrst)
		(src == `SRC_DIV16) |-> (den_sel == 10'h010 && mul_sel == 10'h001))
		else $error("divide-by-16 ratio wrong");

	rc_post_ratio_a: assert property (@(posedge clk) disable iff (!nrst)
		(src == `SRC_DIVN && rc_post == 3'h7) |-> (den_sel == 10'h100))
		else $error("rc postscale 111 is not 256");

	pll_ratio_a: assert property (@(posedge clk) disable iff (!nrst)
		(src == `SRC_PRI_PLL && pll_pre == 5'h00 && fbd == 9'h01E && pll_post == 2'h0)
		|-> (mul_sel == 10'h020 && den_sel == 10'h004))
		else $error("pll ratio does not follow M over N1 times N2");

	release_time_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(exec_release) |-> ($past(state, 2) == ST_SETTLE && $past(settle, 2) == 8'(STARTUP_CNT - 1)))
		else $error("execution released before settle finished");

	post_reset_a: assert property (@(posedge clk) disable iff (!nrst)
		(nrst && state == ST_CAPTURE)
		|-> (pll_post == 2'h1))
		else $error("postscale field not at its reset default");

	osc2_crystal_a: assert property (@(posedge clk) disable iff (!nrst)
		(exec_release && is_primary && submode == `SUB_XT) |-> !osc2_pin_is_io)
		else $error("crystal mode released the second pin as io");

	low_power_internal_rc_ref_a: assert property (@(posedge clk) disable iff (!nrst)
		low_power_internal_rc_ref_tick |-> $past(osc_pins.edge_tick[PIN_LOW_POWER_INTERNAL_RC]))
		else $error("reference tick without low-power rc edge");
endmodule

// ===== bench/osc_source_model.sv
// free-running oscillator sources that drive the clock select pins
`timescale 1ns/1ps
module osc_source_model (
	// oscillator pins
	output logic fast_rc_pin,
	output logic primary_osc_pin,
	output logic secondary_osc_pin,
	output logic low_power_rc_pin
);
	// odd start offsets keep pin edges away from clk edges; periods 8, 10, 12, 20 clk cycles
	initial begin
		fast_rc_pin = 1'b0;
		#0.3;
		forever #16 fast_rc_pin = ~fast_rc_pin;
	end
	initial begin
		primary_osc_pin = 1'b0;
		#0.7;
		forever #20 primary_osc_pin = ~primary_osc_pin;
	end
	initial begin
		secondary_osc_pin = 1'b0;
		#1.1;
		forever #24 secondary_osc_pin = ~secondary_osc_pin;
	end
	// slow rc runs free; it feeds the low-power rc reference tick
	initial begin
		low_power_rc_pin = 1'b0;
		#1.3;
		forever #40 low_power_rc_pin = ~low_power_rc_pin;
	end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps
module testbench;
	logic clk, nrst, osc_pin_function_bit, config_erased, reg_wr, reg_rd;
	logic [2:0] initial_source_select;
	logic [1:0] primary_submode_select;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic fast_rc_pin, primary_osc_pin, secondary_osc_pin, low_power_rc_pin;
	logic osc_tick, instr_tick, low_power_internal_rc_ref_tick, osc2_pin_is_io, exec_release;
	int failures, comparisons, cycles;

	osc_source_model u_osc (
		.fast_rc_pin(fast_rc_pin),
		.primary_osc_pin(primary_osc_pin),
		.secondary_osc_pin(secondary_osc_pin),
		.low_power_rc_pin(low_power_rc_pin)
	);

	clock_select u_dut (
		.clk(clk),
		.nrst(nrst),
		.initial_source_select(initial_source_select),
		.primary_submode_select(primary_submode_select),
		.osc_pin_function_bit(osc_pin_function_bit),
		.config_erased(config_erased),
		.fast_rc_pin(fast_rc_pin),
		.primary_osc_pin(primary_osc_pin),
		.secondary_osc_pin(secondary_osc_pin),
		.low_power_rc_pin(low_power_rc_pin),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.osc_tick(osc_tick),
		.instr_tick(instr_tick),
		.low_power_internal_rc_ref_tick(low_power_internal_rc_ref_tick),
		.osc2_pin_is_io(osc2_pin_is_io),
		.exec_release(exec_release)
	);

	// 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard, well above the roughly 47000 cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			failures++;
			report_and_stop;
		end
	end

	task report_and_stop;
		if (failures == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// the scaler is rate-accurate only on average, so allow a few ticks of slack
	task near(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got + 3 < exp || got > exp + 3) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task write_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand one cycle only, then fall back to zero
	task read_reg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
		@(posedge clk);
		#1;
		check(reg_rdata, 16'h0000);
	endtask

	// reset with a configuration, time the release, then judge the status word
	task boot(input logic [2:0] src, input logic [1:0] sub, input logic io, input logic erased);
		logic [2:0] s;
		logic prim;
		int n;
		@(posedge clk);
		nrst <= 1'b0;
		initial_source_select <= src;
		primary_submode_select <= sub;
		osc_pin_function_bit <= io;
		config_erased <= erased;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		n = 0;
		while (exec_release !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n, 18);
		s = erased ? 3'h7 : src;
		prim = (s[2:1] == 2'h1);
		read_reg(4'h2, {8'h00, (prim && sub != 2'h0) ? 1'b0 : io, 1'b1, (s == 3'h1 || s == 3'h3),
			prim ? sub : 2'h0, s});
		check(osc2_pin_is_io, (prim && sub != 2'h0) ? 1'b0 : io);
	endtask

	// count ticks over 3200 cycles; slow rc rises 160 times in that span
	task measure(input logic [31:0] exp);
		int no, ni, nl;
		no = 0;
		ni = 0;
		nl = 0;
		repeat (40) @(posedge clk);
		repeat (3200) begin
			@(posedge clk);
			#1;
			if (osc_tick === 1'b1) no++;
			if (instr_tick === 1'b1) ni++;
			if (low_power_internal_rc_ref_tick === 1'b1) nl++;
		end
		near(no, exp);
		near(ni, exp / 2);
		near(nl, 160);
	endtask

	task test_registers;
		boot(3'h0, 2'h0, 1'b0, 1'b0);
		read_reg(4'h0, 16'h0040);
		read_reg(4'h1, 16'h0030);
		read_reg(4'h3, 16'h0000);
		write_reg(4'h0, 16'hFFFF);
		read_reg(4'h0, 16'h07DF);
		write_reg(4'h1, 16'hFFFF);
		read_reg(4'h1, 16'h01FF);
		write_reg(4'h2, 16'hFFFF);
		write_reg(4'hF, 16'h0000);
		read_reg(4'h2, 16'h0040);
		read_reg(4'h0, 16'h07DF);
	endtask

	// every source code against every primary submode
	task test_modes;
		logic [2:0] c;
		logic [1:0] m;
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 3; j++) begin
				c = 3'(i);
				m = 2'(j);
				boot(c, m, c[0] ^ m[0], 1'b0);
			end
		end
		boot(3'h0, 2'h1, 1'b1, 1'b1);
	endtask

	// pll settings keep the scaled rate below one tick per cycle
	task test_rates;
		boot(3'h0, 2'h0, 1'b0, 1'b0);
		write_reg(4'h0, 16'h0740);
		measure(400);
		boot(3'h7, 2'h0, 1'b0, 1'b0);
		measure(400);
		write_reg(4'h0, 16'h0240);
		measure(100);
		write_reg(4'h0, 16'h0340);
		measure(50);
		write_reg(4'h0, 16'h0740);
		measure(2);
		boot(3'h6, 2'h0, 1'b0, 1'b0);
		measure(25);
		boot(3'h1, 2'h0, 1'b0, 1'b0);
		write_reg(4'h1, 16'h0006);
		write_reg(4'h0, 16'h0000);
		measure(800);
		write_reg(4'h0, 16'h00C0);
		measure(200);
		write_reg(4'h0, 16'h0001);
		measure(533);
		boot(3'h3, 2'h2, 1'b0, 1'b0);
		measure(2000);
		write_reg(4'h1, 16'h001E);
		write_reg(4'h0, 16'h0000);
		measure(2560);
		boot(3'h2, 2'h0, 1'b1, 1'b0);
		measure(320);
		boot(3'h4, 2'h0, 1'b0, 1'b0);
		write_reg(4'h1, 16'h0006);
		write_reg(4'h0, 16'h0000);
		measure(267);
		boot(3'h5, 2'h0, 1'b0, 1'b0);
		measure(160);
	endtask

	initial begin
		failures = 0;
		comparisons = 0;
		cycles = 0;
		nrst = 1'b0;
		initial_source_select = 3'h0;
		primary_submode_select = 2'h0;
		osc_pin_function_bit = 1'b0;
		config_erased = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		test_registers;
		test_modes;
		test_rates;
		report_and_stop;
	end
endmodule
